// file: rst_cfg_pkg.sv
// How it works
// RULE_01 - reset pin low holds all registers default
// RULE_02 - reset pin release starts boot controller
// RULE_03 - controller pulses reset pin at least 1us
// RULE_04 - hard reset spares iface, itself, address, if-field
// RULE_05 - hard reset: writes accepted, reads refused
// RULE_06 - hard clear resamples test, select; keeps iface
// RULE_07 - boot starts 1 to 3us after hard clear
// RULE_08 - soft reset spares iface, both bits, address, cfgstatus
// RULE_09 - soft reset never starts boot controller
// RULE_10 - host waits 100us and boot done first; host waits out the 100us only, not boot done
// RULE_11 - eight stored configs chosen by select pins
// RULE_12 - iface pins 11 choose external source; code only sets ext_src, the same stored table serves both
// RULE_13 - test,000,11 at release enters direct write mode
// RULE_14 - direct write mode drives miso continuously
// RULE_15 - pin0 follows boot done via 0x1F, 0x04
// RULE_16 - writers put zero in reserved bits
// RULE_17 - read-only fields ignore writes
// RULE_18 - live status read-only; latched bits write-one-clear
// RULE_19 - latched bit raises request only when enabled
// RULE_20 - configuration fields default while in reset
// RULE_21 - address 0 is bank select, switches upper map
// RULE_22 - bit 7 most significant in each register
// RULE_23 - boot done sits at bit 7 of 43h
// RULE_24 - boot done set when config fully applied
package rst_cfg_pkg;
	// timing, figures in ns at the 50 MHz clock
	localparam int CLK_PERIOD_NS = 20;
	localparam int RST_HOLD_NS = 1000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HARD_RESET_BIT_MIN_NS = 1000;
	localparam int HARD_RESET_BIT_MAX_NS = 3000;
	localparam int HARD_RESET_BIT_MIN_CYC = (HARD_RESET_BIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HARD_RESET_BIT_MAX_CYC = HARD_RESET_BIT_MAX_NS / CLK_PERIOD_NS;
	// aim mid-window so both bounds keep margin
	localparam int HARD_RESET_BIT_DELAY_CYC = (HARD_RESET_BIT_MIN_CYC + HARD_RESET_BIT_MAX_CYC) / 2;
	localparam int SETTLE_NS = 100000;
	localparam int SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
	localparam int BOOT_CYC_DEF = 16;
	localparam int EE_AW_DEF = 6;
	////////////////////////////////////////////////////////////////////////
	// device register offsets
	localparam logic [15:0] A_BANK = 16'h0000;
	localparam logic [15:0] A_MCR = 16'h0001;
	localparam logic [15:0] A_PFC1 = 16'h000B;
	localparam logic [15:0] A_P0SS = 16'h000D;
	localparam logic [15:0] A_SADDR = 16'h0011;
	localparam logic [15:0] A_CONFIG_STATUS_REG = 16'h0040;
	localparam logic [15:0] A_GISR = 16'h0043;
	// fields
	localparam int BANK_BIT = 7;
	localparam int SOFT_BIT = 7;
	localparam int HARD_BIT = 6;
	localparam int BD_BIT = 7;
	localparam int BD_IE_BIT = 6;
	localparam logic [7:0] MCR_MASK = 8'hC0;
	localparam logic [7:0] SADDR_MASK = 8'h7F;
	localparam logic [7:0] SADDR_RST = 8'h74;
	localparam logic [7:0] PFC1_RST = 8'h00;
	localparam logic [7:0] P0SS_RST = 8'h00;
	localparam logic [7:0] SS_BOOT_DONE = 8'h1F;
	localparam logic [3:0] FN_STATUS_OUT = 4'h4;
	localparam logic [2:0] AC_DIRECT = 3'h0;
	localparam logic [1:0] IF_EXT = 2'h3;
	// stored configurations, entry 0 rightmost
	localparam logic [7:0][7:0] CFG_P0SS = 64'h00000000_0000001F;
	localparam logic [7:0][7:0] CFG_PFC1 = 64'h00000000_00000004;
	////////////////////////////////////////////////////////////////////////
	// host register offsets (byte addresses)
	localparam logic [7:0] H_CTRL = 8'h00;
	localparam logic [7:0] H_STRAP = 8'h04;
	localparam logic [7:0] H_CMD = 8'h08;
	localparam logic [7:0] H_STAT = 8'h0C;
	localparam int CMD_WE_BIT = 24;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0] {
		DS_SAMPLE = 5'h01,
		DS_HOLD = 5'h02,
		DS_DELAY = 5'h04,
		DS_BOOT = 5'h08,
		DS_RUN = 5'h10
	} dev_state_t;
	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_RST = 4'h2,
		HS_SETTLE = 4'h4,
		HS_BUSY = 4'h8
	} host_state_t;
	typedef struct packed {
		dev_state_t st;
		logic [7:0] cnt;
		logic [7:0] bank;
		logic [7:0] mcr;
		logic [7:0] saddr;
		logic [7:0] pfc1;
		logic [7:0] p0ss;
		logic [1:0] ifs;
		logic test;
		logic [2:0] ac;
		logic ext_src;
		logic cfgd;
		logic dmode;
		logic bdone;
		logic bd_ie;
		logic ack;
		logic [7:0] rdata;
		logic miso_oe;
		logic gpio0;
		logic irq;
	} dev_regs_t;
	typedef struct packed {
		host_state_t st;
		logic [15:0] cnt;
		logic settled;
		logic [5:0] strap;
		logic [24:0] cmd;
		logic pin_n;
		logic req;
		logic [7:0] rdata;
		logic ack;
		logic [31:0] dat;
	} host_regs_t;
endpackage : rst_cfg_pkg

// file: rst_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rst_cfg_if;
	logic ext_reset_pin_n;
	logic test_pin;
	logic [2:0] autoconfig_select_pins;
	logic [1:0] if_select_pins;
	logic reg_req;
	logic reg_we;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_ack;
	logic [7:0] reg_rdata;
	logic miso_oe;
	logic gpio0;
	logic irq;
	modport dev (
		input ext_reset_pin_n, test_pin, autoconfig_select_pins, if_select_pins,
		input reg_req, reg_we, reg_addr, reg_wdata,
		output reg_ack, reg_rdata, miso_oe, gpio0, irq
	);
	modport host (
		output ext_reset_pin_n, test_pin, autoconfig_select_pins, if_select_pins,
		output reg_req, reg_we, reg_addr, reg_wdata,
		input reg_ack, reg_rdata, miso_oe, gpio0, irq
	);
endinterface : rst_cfg_if
`default_nettype wire

// file: reset_and_autoconfig_control.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module reset_and_autoconfig_control #(
	parameter int BOOT_CYC = rst_cfg_pkg::BOOT_CYC_DEF,
	parameter int EE_AW = rst_cfg_pkg::EE_AW_DEF
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	rst_cfg_if.dev link,
	output logic boot_done_o,
	output logic direct_mode_o
);
	rst_cfg_pkg::dev_regs_t r;
	rst_cfg_pkg::dev_regs_t n;
	logic [7:0] ee_mem [2**EE_AW];
	logic areset_n;
	logic take;
	logic ee_sel;
	logic ee_hit;
	logic [EE_AW-1:0] ee_idx;
	logic [7:0] ee_rdata;
	logic [7:0] cfg_status;
	logic [7:0] glob_status;
	logic [7:0] script_p0ss;
	logic [7:0] script_pfc1;

	////////////////////////////////////////////////////////////////////////
	// the pin acts as an asynchronous reset beside the system reset
	assign areset_n = rst_b_i & link.ext_reset_pin_n; // RULE_01
	// one take per request: the host drops req on the edge that sees ack
	assign take = link.reg_req & ~r.ack;
	// address 0 never leaves the register bank
	assign ee_sel = (r.dmode | r.bank[rst_cfg_pkg::BANK_BIT]) & (link.reg_addr != rst_cfg_pkg::A_BANK); // RULE_21
	assign ee_hit = ee_sel & ((link.reg_addr >> EE_AW) == 16'h0000);
	assign ee_idx = link.reg_addr[EE_AW-1:0];
	// out-of-range memory reads answer zero rather than wrapping onto a low place
	assign ee_rdata = ee_hit ? ee_mem[ee_idx] : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// readable status words, bit 7 most significant
	assign cfg_status = {r.cfgd, 1'b0, r.ifs, r.test, r.ac}; // RULE_22
	assign glob_status = {r.bdone, r.bd_ie, 6'h00}; // RULE_23
	// script chosen by the straps caught at release or hard clear; one table serves both sources
	assign script_p0ss = rst_cfg_pkg::CFG_P0SS[r.ac]; // RULE_11
	assign script_pfc1 = rst_cfg_pkg::CFG_PFC1[r.ac]; // RULE_11

	////////////////////////////////////////////////////////////////////////
	// next state: host writes first, hardware events after, resets last
	always_comb begin
		n = r;
		n.ack = take;
		n.rdata = 8'h00;

		// register writes stay open under hard reset so it can be cleared
		if (take && link.reg_we && !ee_sel) begin // RULE_05
			unique case (link.reg_addr)
				rst_cfg_pkg::A_BANK: begin
					// only the select bit is stored; the rest reads back zero
					n.bank = 8'h00;
					n.bank[rst_cfg_pkg::BANK_BIT] = link.reg_wdata[rst_cfg_pkg::BANK_BIT]; // RULE_21
				end
				rst_cfg_pkg::A_MCR: n.mcr = link.reg_wdata & rst_cfg_pkg::MCR_MASK;
				rst_cfg_pkg::A_PFC1: n.pfc1 = link.reg_wdata;
				rst_cfg_pkg::A_P0SS: n.p0ss = link.reg_wdata;
				rst_cfg_pkg::A_SADDR: n.saddr = link.reg_wdata & rst_cfg_pkg::SADDR_MASK;
				rst_cfg_pkg::A_GISR: begin
					n.bd_ie = link.reg_wdata[rst_cfg_pkg::BD_IE_BIT];
					if (link.reg_wdata[rst_cfg_pkg::BD_BIT]) begin
						n.bdone = 1'b0; // RULE_18
					end
				end
				default: ; // status and unmapped offsets ignore writes RULE_17
			endcase
		end

		// reads answer zero while the hard reset bit stands
		if (take && !link.reg_we && !r.mcr[rst_cfg_pkg::HARD_BIT]) begin // RULE_05
			if (ee_sel) begin
				n.rdata = ee_rdata;
			end else begin
				unique case (link.reg_addr)
					rst_cfg_pkg::A_BANK: n.rdata = r.bank;
					rst_cfg_pkg::A_MCR: n.rdata = r.mcr;
					rst_cfg_pkg::A_PFC1: n.rdata = r.pfc1;
					rst_cfg_pkg::A_P0SS: n.rdata = r.p0ss;
					rst_cfg_pkg::A_SADDR: n.rdata = r.saddr;
					rst_cfg_pkg::A_CONFIG_STATUS_REG: n.rdata = cfg_status; // RULE_22
					rst_cfg_pkg::A_GISR: n.rdata = glob_status; // RULE_23
					default: n.rdata = 8'h00;
				endcase
			end
		end

		// boot sequencing
		unique case (r.st)
			rst_cfg_pkg::DS_SAMPLE: begin
				// straps caught one clock after the pin releases
				n.test = link.test_pin;
				n.ac = link.autoconfig_select_pins;
				n.ifs = link.if_select_pins;
				n.ext_src = (link.if_select_pins == rst_cfg_pkg::IF_EXT); // RULE_12
				n.dmode = link.test_pin && (link.autoconfig_select_pins == rst_cfg_pkg::AC_DIRECT)
					&& (link.if_select_pins == rst_cfg_pkg::IF_EXT); // RULE_13
				// direct mode skips the script so the array stays free for writing
				n.cnt = 8'h00;
				n.st = n.dmode ? rst_cfg_pkg::DS_RUN : rst_cfg_pkg::DS_BOOT; // RULE_02
			end
			rst_cfg_pkg::DS_HOLD: begin
				if (!n.mcr[rst_cfg_pkg::HARD_BIT]) begin
					// interface pins deliberately not resampled
					// the delay is counted from the clearing write
					n.test = link.test_pin; // RULE_06
					n.ac = link.autoconfig_select_pins; // RULE_06
					n.cnt = 8'h00;
					n.st = rst_cfg_pkg::DS_DELAY;
				end
			end
			rst_cfg_pkg::DS_DELAY: begin
				n.cnt = r.cnt + 8'h01;
				// fixed count mid-window, so clock tolerance eats into neither bound
				if (r.cnt == 8'(rst_cfg_pkg::HARD_RESET_BIT_DELAY_CYC - 1)) begin // RULE_07
					n.cnt = 8'h00;
					n.st = rst_cfg_pkg::DS_BOOT;
				end
			end
			rst_cfg_pkg::DS_BOOT: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt == 8'(BOOT_CYC - 1)) begin
					// the chosen script lands in one step at the end
					n.p0ss = script_p0ss; // RULE_11
					n.pfc1 = script_pfc1; // RULE_11
					n.bdone = 1'b1; // RULE_24
					n.cfgd = 1'b1;
					n.cnt = 8'h00;
					n.st = rst_cfg_pkg::DS_RUN;
				end
			end
			rst_cfg_pkg::DS_RUN: ;
			default: n.st = rst_cfg_pkg::DS_RUN;
		endcase

		// hard reset wins over soft; both sit after the write above
		if (n.mcr[rst_cfg_pkg::HARD_BIT]) begin
			// soft bit falls too, so clearing hard later never leaves the block held
			n.mcr = 8'h00;
			n.mcr[rst_cfg_pkg::HARD_BIT] = 1'b1; // RULE_04
			n.bank = 8'h00;
			n.pfc1 = rst_cfg_pkg::PFC1_RST;
			n.p0ss = rst_cfg_pkg::P0SS_RST;
			n.test = 1'b0;
			n.ac = 3'h0;
			n.cfgd = 1'b0;
			n.dmode = 1'b0;
			n.bdone = 1'b0;
			n.bd_ie = 1'b0;
			n.cnt = 8'h00;
			n.st = rst_cfg_pkg::DS_HOLD;
		end else if (n.mcr[rst_cfg_pkg::SOFT_BIT]) begin
			// config status and slave address survive
			n.bank = 8'h00; // RULE_08
			n.pfc1 = rst_cfg_pkg::PFC1_RST;
			n.p0ss = rst_cfg_pkg::P0SS_RST;
			n.bdone = 1'b0;
			n.bd_ie = 1'b0;
			n.cnt = 8'h00;
			n.st = rst_cfg_pkg::DS_RUN; // RULE_09
		end

		// outputs, all registered
		n.miso_oe = n.dmode | (take & ~link.reg_we); // RULE_14
		// pin and request use the next-state copy so they move with boot done
		n.gpio0 = (n.p0ss == rst_cfg_pkg::SS_BOOT_DONE)
			&& (n.pfc1[$bits(rst_cfg_pkg::FN_STATUS_OUT)-1:0] == rst_cfg_pkg::FN_STATUS_OUT)
			&& n.bdone;
		n.irq = n.bdone & n.bd_ie; // RULE_19
	end

	////////////////////////////////////////////////////////////////////////
	// every field takes its default while either reset is low
	always_ff @(posedge clk_i or negedge areset_n) begin
		if (!areset_n) begin
			r <= '0; // RULE_20
			r.st <= rst_cfg_pkg::DS_SAMPLE;
			r.saddr <= rst_cfg_pkg::SADDR_RST;
			r.pfc1 <= rst_cfg_pkg::PFC1_RST;
			r.p0ss <= rst_cfg_pkg::P0SS_RST;
		end else begin
			r <= n;
		end
	end

	// nonvolatile store: no reset, survives every reset kind
	// a place read before it was ever written returns unknowns
	always_ff @(posedge clk_i) begin
		if (take && link.reg_we && ee_hit) begin
			ee_mem[ee_idx] <= link.reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign link.reg_ack = r.ack;
	assign link.reg_rdata = r.rdata;
	assign link.miso_oe = r.miso_oe;
	assign link.gpio0 = r.gpio0;
	assign link.irq = r.irq;
	assign boot_done_o = r.bdone;
	assign direct_mode_o = r.dmode;
endmodule : reset_and_autoconfig_control
`default_nettype wire

// file: rst_cfg_host.sv
`timescale 1ns/100ps
`default_nettype none
module rst_cfg_host #(
	parameter int SETTLE_CYC = rst_cfg_pkg::SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	rst_cfg_if.host link
);
	rst_cfg_pkg::host_regs_t r;
	rst_cfg_pkg::host_regs_t n;
	logic wb_take;
	logic [31:0] m;
	logic [31:0] cmd_w;

	////////////////////////////////////////////////////////////////////////
	assign wb_take = wb_cyc_i & wb_stb_i & ~r.ack;
	assign m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign cmd_w = ({7'h00, r.cmd} & ~m) | (wb_dat_i & m);

	////////////////////////////////////////////////////////////////////////
	// bus slave and link sequencer in one next-state process
	always_comb begin
		n = r;
		n.ack = wb_take;
		if (wb_take && !wb_we_i) begin
			unique case (wb_adr_i)
				rst_cfg_pkg::H_CTRL: n.dat = {31'h0, ~r.pin_n};
				rst_cfg_pkg::H_STRAP: n.dat = {26'h0, r.strap};
				rst_cfg_pkg::H_CMD: n.dat = {7'h00, r.cmd};
				rst_cfg_pkg::H_STAT: n.dat = {16'h0, r.rdata, 4'h0, link.irq, link.gpio0, r.settled,
					r.st != rst_cfg_pkg::HS_IDLE};
				default: n.dat = 32'h0;
			endcase
		end
		if (wb_take && wb_we_i && wb_adr_i == rst_cfg_pkg::H_STRAP && wb_sel_i[0]) begin
			n.strap = wb_dat_i[5:0];
		end
		unique case (r.st)
			rst_cfg_pkg::HS_IDLE: begin
				if (wb_take && wb_we_i && wb_adr_i == rst_cfg_pkg::H_CTRL && wb_sel_i[0] && wb_dat_i[0]) begin
					n.pin_n = 1'b0;
					n.cnt = 16'h0;
					n.st = rst_cfg_pkg::HS_RST;
				end else if (wb_take && wb_we_i && wb_adr_i == rst_cfg_pkg::H_CMD) begin
					n.cmd = cmd_w[24:0];
					n.req = 1'b1;
					n.st = rst_cfg_pkg::HS_BUSY;
				end
			end
			rst_cfg_pkg::HS_RST: begin
				n.cnt = r.cnt + 16'h1;
				if (r.cnt == 16'(rst_cfg_pkg::RST_HOLD_CYC - 1)) begin // RULE_03
					n.pin_n = 1'b1;
					n.cnt = 16'h0;
					n.settled = 1'b0;
					n.st = rst_cfg_pkg::HS_SETTLE;
				end
			end
			rst_cfg_pkg::HS_SETTLE: begin
				// device commands written now are dropped, not queued
				n.cnt = r.cnt + 16'h1;
				if (r.cnt == 16'(SETTLE_CYC - 1)) begin // RULE_10
					n.settled = 1'b1;
					n.st = rst_cfg_pkg::HS_IDLE;
				end
			end
			rst_cfg_pkg::HS_BUSY: begin
				if (link.reg_ack) begin
					n.req = 1'b0;
					n.rdata = r.cmd[rst_cfg_pkg::CMD_WE_BIT] ? r.rdata : link.reg_rdata;
					n.st = rst_cfg_pkg::HS_IDLE;
				end
			end
			default: n.st = rst_cfg_pkg::HS_IDLE;
		endcase
	end

	// power-up begins with the pin pulled low
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
			r.st <= rst_cfg_pkg::HS_RST; // RULE_03
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign link.ext_reset_pin_n = r.pin_n;
	assign link.test_pin = r.strap[3];
	assign link.autoconfig_select_pins = r.strap[2:0];
	assign link.if_select_pins = r.strap[5:4];
	assign link.reg_req = r.req;
	assign link.reg_we = r.cmd[rst_cfg_pkg::CMD_WE_BIT];
	assign link.reg_addr = r.cmd[15:0];
	assign link.reg_wdata = r.cmd[23:16];
endmodule : rst_cfg_host
`default_nettype wire

// file: rst_cfg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rst_cfg_assertions (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ext_reset_pin_n,
	input wire logic reg_req,
	input wire logic reg_we,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic [7:0] reg_rdata,
	input wire logic miso_oe,
	input wire logic gpio0,
	input wire logic irq,
	input wire logic boot_done_o,
	input wire logic direct_mode_o
);
	logic hard_reg;
	logic soft_reg;
	logic mcr_wr;
	logic hard_clr;
	logic soft_clr;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////////////
	// mirror of both reset bits, fed by completed writes and cleared while the pin is low
	assign mcr_wr = reg_ack && reg_we && reg_addr == rst_cfg_pkg::A_MCR;
	assign hard_clr = mcr_wr && hard_reg && reg_wdata[7:6] == 2'b00;
	assign soft_clr = mcr_wr && soft_reg && reg_wdata[7:6] == 2'b00;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hard_reg <= 1'b0;
			soft_reg <= 1'b0;
		end else if (!ext_reset_pin_n || mcr_wr) begin
			hard_reg <= ext_reset_pin_n && reg_wdata[6];
			soft_reg <= ext_reset_pin_n && reg_wdata[7];
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_quiet; !ext_reset_pin_n |-> !reg_ack && !gpio0 && !irq && !boot_done_o; endproperty
	a_quiet: assert property (p_quiet) else $error("outputs active in reset");
	property p_pin; $fell(ext_reset_pin_n) |-> ##49 !ext_reset_pin_n; endproperty
	a_pin: assert property (p_pin) else $error("reset pulse too short");
	property p_ans; reg_req && !reg_ack && ext_reset_pin_n |=> reg_ack ##1 !reg_ack; endproperty
	a_ans: assert property (p_ans) else $error("link answer late or long");
	// boot may not finish at once, but must within a short bound
	property p_boot; $rose(ext_reset_pin_n) |-> !boot_done_o[*3] ##[1:40] (boot_done_o || direct_mode_o); endproperty
	a_boot: assert property (p_boot) else $error("boot not run after release");
	property p_hard; hard_clr |-> ##49 !boot_done_o ##[1:110] boot_done_o; endproperty
	a_hard: assert property (p_hard) else $error("boot delay after hard clear wrong");
	property p_hard_rd; reg_ack && !reg_we && hard_reg |-> reg_rdata == 8'h00; endproperty
	a_hard_rd: assert property (p_hard_rd) else $error("read served in hard reset");
	property p_soft; soft_reg |=> !boot_done_o && !irq && !gpio0; endproperty
	a_soft: assert property (p_soft) else $error("soft reset left status set");
	property p_soft_clr; soft_clr |=> !boot_done_o[*8]; endproperty
	a_soft_clr: assert property (p_soft_clr) else $error("boot after soft reset");
	property p_direct; direct_mode_o && $past(direct_mode_o) |-> miso_oe && !boot_done_o; endproperty
	a_direct: assert property (p_direct) else $error("miso idle in direct mode");
	property p_outs; irq || gpio0 |-> boot_done_o || $past(boot_done_o); endproperty
	a_outs: assert property (p_outs) else $error("irq or pin without boot done");
endmodule : rst_cfg_assertions
`default_nettype wire

// file: reset_and_autoconfig_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module reset_and_autoconfig_control_test;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rdq;
	logic ack;
	logic boot_done_o;
	logic direct_mode_o;
	logic [7:0] rd;
	logic [7:0] sa;
	logic [5:0] s;
	int errors = 0;
	int check_count = 0;
	int seed = 32'hA07F;
	rst_cfg_if link ();
	// short boot and settle keep every pin reset near seventy cycles, 50 low and 20 settling
	reset_and_autoconfig_control #(.BOOT_CYC(4)) reset_and_autoconfig_control_inst (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .link(link.dev), .boot_done_o(boot_done_o), .direct_mode_o(direct_mode_o));
	rst_cfg_host #(.SETTLE_CYC(20)) rst_cfg_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .link(link.host));
	rst_cfg_assertions rst_cfg_assertions_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.ext_reset_pin_n(link.ext_reset_pin_n), .reg_req(link.reg_req), .reg_we(link.reg_we),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
		.reg_rdata(link.reg_rdata), .miso_oe(link.miso_oe), .gpio0(link.gpio0), .irq(link.irq),
		.boot_done_o(boot_done_o), .direct_mode_o(direct_mode_o));
	initial forever #10 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic give_up();
		errors++;
		report_and_stop();
	endtask : give_up
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// config status expected: interface field given apart, it survives hard reset
	function automatic logic [7:0] status_exp(input logic [5:0] st, input logic [1:0] ifs);
		return {2'b00, ifs, st[3:0]};
	endfunction : status_exp
	function automatic logic [7:0] pin_exp(input logic [2:0] ac);
		return (ac == 3'h0) ? 8'h04 : 8'h00;
	endfunction : pin_exp
	////////////////////////////////////////////////////////////////////////
	// one classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc, we, adr, wdat} <= {1'b1, w, a, d};
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		if (n == 100) give_up();
		rdq = rdat;
		cyc <= 1'b0;
	endtask : wb
	// device access through the command register, polled until not busy
	task automatic dev(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		wb(1'b1, rst_cfg_pkg::H_CMD, {7'h00, w, d, a});
		for (n = 0; n < 100; n++) begin
			wb(1'b0, rst_cfg_pkg::H_STAT, 32'h0);
			if (rdq[0] === 1'b0) break;
		end
		if (n == 100) give_up();
		rd = rdq[15:8];
	endtask : dev
	task automatic settle();
		int n;
		for (n = 0; n < 300; n++) begin
			wb(1'b0, rst_cfg_pkg::H_STAT, 32'h0);
			if (rdq[1:0] === 2'b10) break;
		end
		if (n == 300) give_up();
	endtask : settle
	// straps must be in place before the pin pulse starts
	task automatic pulse(input logic [5:0] st);
		wb(1'b1, rst_cfg_pkg::H_STRAP, {26'h0, st});
		wb(1'b1, rst_cfg_pkg::H_CTRL, 32'h1);
		settle();
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		settle();
		// strap sets: all high first, no straps last; test strap kept low here
		for (int i = 0; i < 4; i++) begin
			s = (i == 0) ? 6'h37 : (i == 3) ? 6'h00 : 6'($random(seed)) & 6'h37;
			pulse(s);
			dev(1'b0, rst_cfg_pkg::A_CONFIG_STATUS_REG, 8'h00);
			check("config_status", status_exp(s, s[5:4]), rd & 8'h3F);
			dev(1'b0, rst_cfg_pkg::A_GISR, 8'h00);
			check("boot_done", 8'h80, rd & 8'h80);
			check("boot_done_pin", 8'h01, {7'h00, boot_done_o});
			wb(1'b0, rst_cfg_pkg::H_STAT, 32'h0);
			check("gpio0", pin_exp(s[2:0]), rdq[7:0] & 8'h04);
		end
		// bank switch, address register, read-only field, unmapped place
		dev(1'b0, rst_cfg_pkg::A_SADDR, 8'h00);
		check("slave_addr", rst_cfg_pkg::SADDR_RST, rd);
		dev(1'b1, rst_cfg_pkg::A_BANK, 8'h80);
		dev(1'b1, rst_cfg_pkg::A_SADDR, 8'h5A);
		dev(1'b0, rst_cfg_pkg::A_SADDR, 8'h00);
		check("eeprom_bank", 8'h5A, rd);
		dev(1'b1, rst_cfg_pkg::A_BANK, 8'h00);
		dev(1'b0, rst_cfg_pkg::A_SADDR, 8'h00);
		check("slave_addr", rst_cfg_pkg::SADDR_RST, rd);
		// reserved top bit kept zero; a nonzero value lets the refused read show
		sa = (8'($random(seed)) & 8'h7F) | 8'h01;
		dev(1'b1, rst_cfg_pkg::A_SADDR, sa);
		dev(1'b0, rst_cfg_pkg::A_SADDR, 8'h00);
		check("slave_addr", sa, rd);
		dev(1'b1, rst_cfg_pkg::A_CONFIG_STATUS_REG, 8'h3F);
		dev(1'b0, rst_cfg_pkg::A_CONFIG_STATUS_REG, 8'h00);
		check("config_status", 8'h00, rd & 8'h3F);
		dev(1'b0, 16'h0020, 8'h00);
		check("unmapped", 8'h00, rd);
		// enable request; a zero in the latched bit must not clear it
		dev(1'b1, rst_cfg_pkg::A_GISR, 8'h40);
		dev(1'b0, rst_cfg_pkg::A_GISR, 8'h00);
		check("boot_done", 8'hC0, rd & 8'hC0);
		wb(1'b0, rst_cfg_pkg::H_STAT, 32'h0);
		check("irq_gpio0", 8'h0C, rdq[7:0] & 8'h0C);
		dev(1'b1, rst_cfg_pkg::A_GISR, 8'hC0);
		dev(1'b0, rst_cfg_pkg::A_GISR, 8'h00);
		check("boot_done", 8'h40, rd & 8'hC0);
		wb(1'b0, rst_cfg_pkg::H_STAT, 32'h0);
		check("irq_gpio0", 8'h00, rdq[7:0] & 8'h0C);
		dev(1'b1, rst_cfg_pkg::A_GISR, 8'h00);
		// hard reset: reads refused, new straps taken except interface
		dev(1'b1, rst_cfg_pkg::A_MCR, 8'h40);
		dev(1'b0, rst_cfg_pkg::A_SADDR, 8'h00);
		check("hard_read", 8'h00, rd);
		wb(1'b1, rst_cfg_pkg::H_STRAP, 32'h25);
		dev(1'b1, rst_cfg_pkg::A_MCR, 8'h00);
		for (n = 0; n < 60 && rd[7] !== 1'b1; n++) dev(1'b0, rst_cfg_pkg::A_GISR, 8'h00);
		if (n == 60) give_up();
		dev(1'b0, rst_cfg_pkg::A_SADDR, 8'h00);
		check("slave_addr", sa, rd);
		dev(1'b0, rst_cfg_pkg::A_CONFIG_STATUS_REG, 8'h00);
		check("config_status", status_exp(6'h25, 2'b00), rd & 8'h3F);
		// soft reset: config status kept, boot never restarts
		dev(1'b1, rst_cfg_pkg::A_MCR, 8'h80);
		dev(1'b0, rst_cfg_pkg::A_GISR, 8'h00);
		check("soft_boot", 8'h00, rd & 8'h80);
		dev(1'b0, rst_cfg_pkg::A_CONFIG_STATUS_REG, 8'h00);
		check("config_status", status_exp(6'h25, 2'b00), rd & 8'h3F);
		dev(1'b1, rst_cfg_pkg::A_MCR, 8'h00);
		repeat (200) @(posedge clk_i);
		dev(1'b0, rst_cfg_pkg::A_GISR, 8'h00);
		check("soft_boot", 8'h00, rd & 8'h80);
		check("boot_done_pin", 8'h00, {7'h00, boot_done_o});
		// direct write mode entered and left by the pin
		pulse(6'h38);
		check("direct_mode", 8'h01, {7'h00, direct_mode_o});
		check("miso_drive", 8'h01, {7'h00, link.miso_oe});
		dev(1'b1, 16'h0005, sa);
		dev(1'b0, 16'h0005, 8'h00);
		check("eeprom_data", sa, rd);
		pulse(6'h00);
		check("direct_mode", 8'h00, {7'h00, direct_mode_o});
		report_and_stop();
	end
endmodule : reset_and_autoconfig_control_test
`default_nettype wire
